// ===== src/frm_pkg.sv
package frm_pkg;

  // Overvoltage persistence delay and derived cycle count at 40 MHz.
  localparam int unsigned OV_PERSIST_DELAY_US = 10;
  localparam int unsigned CLK_MHZ             = 40;
  localparam int unsigned OV_PERSIST_CYC      = OV_PERSIST_DELAY_US * CLK_MHZ;
  localparam int unsigned STARTUP_CYC         = 16;
  localparam int unsigned CNT_W               = 16;

  typedef enum logic [1:0] {
    FRM_ST_RESET   = 2'b00,
    FRM_ST_STARTUP = 2'b01,
    FRM_ST_RUN     = 2'b10
  } frm_state_e;

  // Raw detector levels, all active high.
  typedef struct packed {
    logic catch_diode_missing;
    logic switch_current_limit;
    logic input_supply_uv;
    logic bandgap_one_uv;
    logic bandgap_two_uv;
    logic vcc_uv;
    logic vcc_short;
    logic charge_pump_one_uv;
    logic charge_pump_one_ov;
    logic charge_pump_two_uv;
  } frm_faults_s;

  typedef struct packed {
    logic master_reset;
    logic power_on_reset_out;
    logic fault_flag_out;
    logic output_enable_indication;
    logic regulators_on;
    logic isolators_on;
    logic spi_enable;
    logic watchdog_enable;
  } frm_outs_s;

endpackage

// ===== src/frm_sync.sv
`timescale 1ns/1ps
module frm_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } frm_sync_s;

  frm_sync_s st_r;
  frm_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d_i;
    st_nxt.stab = st_r.meta;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.stab;
endmodule

// ===== src/frm_fault_response_manager.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Missing catch diode, seen once, latches master reset; everything off.
// - Switch-node current over limit latches master reset; same all-off response.
// - Persistent pump-one overvoltage drops fault flag only, unlatched.
// - Supply, bandgap, internal-supply or pump-one undervoltage forces unlatched reset.
// - Pump-two undervoltage drops isolators, fault flag and output-enable only.
module frm_fault_response_manager #(
  parameter int unsigned OV_PERSIST_CYC = frm_pkg::OV_PERSIST_CYC,
  parameter int unsigned STARTUP_CYC    = frm_pkg::STARTUP_CYC
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  input  wire frm_pkg::frm_faults_s faults_i,
  input  wire logic                 enable_i,
  output frm_pkg::frm_outs_s        outs_o
);

  // Every output bit lives in this state, so each one leaves the block on a flop.
  // The counters are wide enough for the full persistence delay at the core clock.
  typedef struct packed {
    frm_pkg::frm_state_e       state;
    logic                      latched;
    logic                      en_prev;
    logic [frm_pkg::CNT_W-1:0] ov_cnt;
    logic                      ov_flag;
    logic [frm_pkg::CNT_W-1:0] st_cnt;
    frm_pkg::frm_outs_s        outs;
  } frm_state_s;

  localparam int unsigned NSYNC = $bits(frm_pkg::frm_faults_s) + 1;
  localparam logic [frm_pkg::CNT_W-1:0] OV_LIM = frm_pkg::CNT_W'(OV_PERSIST_CYC);
  localparam logic [frm_pkg::CNT_W-1:0] ST_LIM = frm_pkg::CNT_W'(STARTUP_CYC);

  frm_state_s           st_r;
  frm_state_s           st_nxt;
  logic [NSYNC-1:0]     sync_q;
  frm_pkg::frm_faults_s flt;
  logic                 en_s;
  logic                 nonlatched_rst;
  logic                 latch_evt;
  logic                 latch_clr;
  logic                 hold_reset;
  logic                 start_ok;

  // Detectors and enable come from analog blocks outside the clock domain.
  // One bank for all of them keeps their latency equal, so causes and clears stay in order.
  // A detector pulse shorter than one clock period may be missed by this bank.
  frm_sync #(
    .W (NSYNC)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .d_i        ({faults_i, enable_i}),
    .q_o        (sync_q)
  );

  assign flt = frm_pkg::frm_faults_s'(sync_q[NSYNC-1:1]);
  assign en_s = sync_q[0];

  always_comb begin
    st_nxt = st_r;

    // Causes of the unlatched reset mode; the device restarts once all are gone.
    nonlatched_rst = flt.input_supply_uv
                   | flt.bandgap_one_uv
                   | flt.bandgap_two_uv
                   | flt.vcc_uv
                   | flt.vcc_short
                   | flt.charge_pump_one_uv;

    // Catch-diode and switch-current-limit faults need only one sampled detection to latch.
    latch_evt = flt.catch_diode_missing
              | flt.switch_current_limit;

    // A power cycle is a falling enable or the input supply dropping out.
    latch_clr = (st_r.en_prev && !en_s)
              | flt.input_supply_uv;
    st_nxt.en_prev = en_s;

    // A fresh detection wins over a clear in the same cycle.
    if (latch_evt) begin
      st_nxt.latched = 1'b1;
    end else if (latch_clr) begin
      st_nxt.latched = 1'b0;
    end

    // Anything that keeps the device in reset mode, latched or not.
    hold_reset = nonlatched_rst || latch_evt || st_r.latched || !en_s;
    start_ok   = !nonlatched_rst && !st_nxt.latched && !latch_evt && en_s;

    // Overvoltage must persist for the full delay before the flag drops.
    // The count saturates, so a long overvoltage never wraps and re-arms the flag.
    if (!flt.charge_pump_one_ov) begin
      st_nxt.ov_cnt  = '0;
      st_nxt.ov_flag = 1'b0;
    end else if (st_r.ov_cnt >= OV_LIM) begin
      st_nxt.ov_flag = 1'b1;
    end else begin
      st_nxt.ov_cnt = st_r.ov_cnt + 1'b1;
    end

    case (st_r.state)
      frm_pkg::FRM_ST_RESET: begin
        // Reset mode is left only through a full startup, never straight to run.
        st_nxt.st_cnt = '0;
        if (start_ok) begin
          st_nxt.state = frm_pkg::FRM_ST_STARTUP;
        end
      end

      frm_pkg::FRM_ST_STARTUP: begin
        // The count runs one step past the limit, so startup lasts one edge longer.
        st_nxt.st_cnt = st_r.st_cnt + 1'b1;
        if (st_r.st_cnt >= ST_LIM) begin
          st_nxt.state = frm_pkg::FRM_ST_RUN;
        end
      end

      frm_pkg::FRM_ST_RUN: begin
        // Run is left only through the forced return to reset below.
        st_nxt.st_cnt = '0;
      end

      default: begin
        st_nxt.state = frm_pkg::FRM_ST_RESET;
      end
    endcase

    // This comes last so that any reset cause beats the mode decode above.
    if (hold_reset) begin
      st_nxt.state = frm_pkg::FRM_ST_RESET;
    end

    // Output decode from the next state so outputs sit straight on flops.
    // This costs no latency: the outputs move on the same edge as the mode.
    st_nxt.outs.master_reset = nonlatched_rst || st_nxt.latched;
    case (st_nxt.state)
      frm_pkg::FRM_ST_RESET: begin
        st_nxt.outs.power_on_reset_out       = 1'b0;
        st_nxt.outs.fault_flag_out           = 1'b0;
        st_nxt.outs.output_enable_indication = 1'b0;
        st_nxt.outs.regulators_on            = 1'b0;
        st_nxt.outs.isolators_on             = 1'b0;
        st_nxt.outs.spi_enable               = 1'b0;
        st_nxt.outs.watchdog_enable          = 1'b0;
      end

      frm_pkg::FRM_ST_STARTUP: begin
        // Only the rails come up here; the host sees reset until run mode.
        st_nxt.outs.power_on_reset_out       = 1'b0;
        st_nxt.outs.fault_flag_out           = 1'b0;
        st_nxt.outs.output_enable_indication = 1'b0;
        st_nxt.outs.regulators_on            = 1'b1;
        st_nxt.outs.isolators_on             = 1'b0;
        st_nxt.outs.spi_enable               = 1'b0;
        st_nxt.outs.watchdog_enable          = 1'b0;
      end

      frm_pkg::FRM_ST_RUN: begin
        st_nxt.outs.power_on_reset_out       = 1'b1;
        st_nxt.outs.fault_flag_out = !(flt.charge_pump_two_uv || st_nxt.ov_flag);
        st_nxt.outs.output_enable_indication = !flt.charge_pump_two_uv;
        st_nxt.outs.regulators_on            = 1'b1;
        st_nxt.outs.isolators_on             = !flt.charge_pump_two_uv;
        st_nxt.outs.spi_enable               = 1'b1;
        st_nxt.outs.watchdog_enable          = 1'b1;
      end

      default: begin
        st_nxt.outs.power_on_reset_out       = 1'b0;
        st_nxt.outs.fault_flag_out           = 1'b0;
        st_nxt.outs.output_enable_indication = 1'b0;
        st_nxt.outs.regulators_on            = 1'b0;
        st_nxt.outs.isolators_on             = 1'b0;
        st_nxt.outs.spi_enable               = 1'b0;
        st_nxt.outs.watchdog_enable          = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Master power-on reset: reset mode with the master reset indication raised.
      st_r.state                         <= frm_pkg::FRM_ST_RESET;
      st_r.latched                       <= 1'b0;
      st_r.en_prev                       <= 1'b0;
      st_r.ov_cnt                        <= '0;
      st_r.ov_flag                       <= 1'b0;
      st_r.st_cnt                        <= '0;
      st_r.outs.master_reset             <= 1'b1;
      st_r.outs.power_on_reset_out       <= 1'b0;
      st_r.outs.fault_flag_out           <= 1'b0;
      st_r.outs.output_enable_indication <= 1'b0;
      st_r.outs.regulators_on            <= 1'b0;
      st_r.outs.isolators_on             <= 1'b0;
      st_r.outs.spi_enable               <= 1'b0;
      st_r.outs.watchdog_enable          <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign outs_o = st_r.outs;

endmodule

// ===== verification/frm_fault_response_manager_properties.sv
`timescale 1ns/1ps
module frm_checker #(
  parameter int unsigned OV_PERSIST_CYC = 8,
  parameter int unsigned STARTUP_CYC    = 4
) (
  input wire logic                 core_clk_i,
  input wire logic                 rst_b_i,
  input wire frm_pkg::frm_faults_s faults_i,
  input wire logic                 enable_i,
  input wire frm_pkg::frm_outs_s   outs_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_fault_off: assert property (
    $rose(faults_i[9]) || $rose(faults_i[8]) |-> ##4 outs_o == 8'h80) else $error("no off");
  a_diode_latch: assert property (
    $rose(faults_i[9]) ##0 enable_i[*8] |-> outs_o.master_reset) else $error("unlatched");
  a_ov_flag: assert property (
    $fell(outs_o.fault_flag_out) && outs_o.isolators_on |-> outs_o.spi_enable
      && $past(faults_i[1], OV_PERSIST_CYC)) else $error("bad flag");
  a_uv_reset: assert property (
    (|faults_i[7:2]) [*5] |-> outs_o == 8'h80) else $error("no reset");
  a_iso_off: assert property (
    faults_i[0] [*5] |-> !outs_o.isolators_on && !outs_o.fault_flag_out
      && !outs_o.output_enable_indication) else $error("iso on");
  a_fresh_start: assert property (
    $rose(outs_o.power_on_reset_out) |-> $past(outs_o.regulators_on, STARTUP_CYC)
      && !$past(outs_o.power_on_reset_out, STARTUP_CYC)) else $error("no startup");
  c_latch: cover property ($rose(outs_o.master_reset) && enable_i);
  c_ov: cover property ($fell(outs_o.fault_flag_out) && outs_o.isolators_on);
  c_run: cover property ($rose(outs_o.power_on_reset_out));
endmodule
bind frm_fault_response_manager frm_checker #(.OV_PERSIST_CYC(OV_PERSIST_CYC),
  .STARTUP_CYC(STARTUP_CYC)) u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .faults_i(faults_i), .enable_i(enable_i), .outs_o(outs_o));

// ===== verification/frm_host_model.sv
`timescale 1ns/1ps
module frm_host_model (
  input  wire logic core_clk_i,
  input  wire logic on_i,
  output logic      enable_o
);
  initial enable_o = 1'b0;
  always @(posedge core_clk_i) enable_o <= on_i;
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                 core_clk_i = 1'b0;
  logic                 rst_b_i = 1'b0;
  logic                 on = 1'b0;
  logic                 enable_i;
  frm_pkg::frm_faults_s faults_i = '0;
  frm_pkg::frm_outs_s   outs_o;
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  frm_host_model u_host (.core_clk_i(core_clk_i), .on_i(on), .enable_o(enable_i));
  frm_fault_response_manager #(.OV_PERSIST_CYC(8), .STARTUP_CYC(4)) uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .faults_i(faults_i),
    .enable_i(enable_i), .outs_o(outs_o));
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [7:0] e);
    @(negedge core_clk_i);
    checks_done++;
    if (outs_o !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, outs_o, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_latch(input logic [9:0] m);
    w(1);
    faults_i <= m;
    w(1);
    faults_i <= '0;
    w(10);
    chk(8'h80);
    w(1);
    on <= 1'b0;
    w(6);
    chk(8'h00);
    w(1);
    on <= 1'b1;
    w(20);
    chk(8'h7F);
    $display("t_latch %h done", m);
  endtask
  task automatic t_hold(input logic [9:0] m, input logic [7:0] e);
    w(1);
    faults_i <= m;
    w(16);
    chk(e);
    w(1);
    faults_i <= '0;
    w(20);
    chk(8'h7F);
    $display("t_hold %h done", m);
  endtask
  task automatic t_start;
    w(6);
    chk(8'h08);
    w(14);
    chk(8'h7F);
    $display("t_start done");
  endtask
  task automatic t_vin_clear;
    w(1);
    faults_i <= 10'h200;
    w(1);
    faults_i <= '0;
    w(6);
    chk(8'h80);
    w(1);
    faults_i <= 10'h080;
    w(4);
    chk(8'h80);
    w(1);
    faults_i <= '0;
    w(20);
    chk(8'h7F);
    $display("t_vin_clear done");
  endtask
  task automatic t_ov;
    w(1);
    faults_i <= 10'h002;
    w(6);
    chk(8'h7F);
    w(10);
    chk(8'h5F);
    w(1);
    faults_i <= '0;
    w(8);
    chk(8'h7F);
    $display("t_ov done");
  endtask
  initial begin
    w(10);
    rst_b_i <= 1'b1;
    on <= 1'b1;
    t_start();
    for (int i = 8; i < 10; i++) t_latch(10'(1 << i));
    for (int i = 2; i < 8; i++) t_hold(10'(1 << i), 8'h80);
    t_hold(10'h001, 8'h4B);
    t_vin_clear();
    t_ov();
    close_out();
  end
  initial begin
    #50000;
    n_mismatch++;
    close_out();
  end
endmodule
